// ### common/pfl_pkg.sv
/*
  Constants for the PWM fault, current-limit and pin control block:
  register offsets, control field positions, reset value, unlock keys,
  source-select codes and mode encodings.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package pfl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [3:0] PFL_OFS_CTRL = 4'h0;
  localparam logic [3:0] PFL_OFS_KEY = 4'h4;
  localparam logic [3:0] PFL_OFS_STAT = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int PFL_LSRC_LSB = 26;
  localparam int PFL_LPOL_BIT = 25;
  localparam int PFL_CURRENT_LIMIT_OVERRIDE_ENABLE_BIT = 24;
  localparam int PFL_FSRC_LSB = 19;
  localparam int PFL_FPOL_BIT = 18;
  localparam int PFL_FMOD_LSB = 16;
  localparam int PFL_HIGH_PIN_OWNERSHIP_BIT = 15;
  localparam int PFL_LOW_PIN_OWNERSHIP_BIT = 14;
  localparam int PFL_HIGH_PIN_POLARITY_BIT = 13;
  localparam int PFL_POLL_BIT = 12;
  localparam int PFL_FDAT_LSB = 4;
  localparam int PFL_LDAT_LSB = 2;

  // Implemented, key-protected and reset values
  localparam logic [31:0] PFL_CTRL_IMPL = 32'h3f7f_f03c;
  localparam logic [31:0] PFL_CTRL_PROT = 32'h3f7b_0000;
  localparam logic [31:0] PFL_CTRL_RST = 32'h0078_0000;

  ////////////////////////////////////////////////////////////////////////
  // Status register bits
  localparam int PFL_ST_FLT_ACT = 0;
  localparam int PFL_ST_LIM_ACT = 1;
  localparam int PFL_ST_FLT_OVR = 2;
  localparam int PFL_ST_LIM_OVR = 3;
  localparam int PFL_ST_UNLOCK = 4;

  ////////////////////////////////////////////////////////////////////////
  // Unlock key words
  localparam logic [15:0] PFL_KEY_FIRST = 16'habcd;
  localparam logic [15:0] PFL_KEY_SECOND = 16'h4321;

  // Source select codes
  localparam logic [3:0] PFL_SRC_PIN15 = 4'hf;
  localparam logic [3:0] PFL_SRC_CMP_LO = 4'h8;
  localparam logic [3:0] PFL_SRC_CMP_HI = 4'hc;

  // Fault override modes
  localparam logic [1:0] PFL_FMOD_LATCH = 2'h0;
  localparam logic [1:0] PFL_FMOD_CYCLE = 2'h1;

  typedef enum logic [1:0] {
    PFL_UNL_IDLE = 2'b00,
    PFL_UNL_KEY1 = 2'b01,
    PFL_UNL_OPEN = 2'b10
  } pfl_unlock_t;

endpackage : pfl_pkg

// ### dv/pfl_pin_ctrl_asserts.sv
/*
  Port-level checker for pfl_pin_ctrl.
  Assumes one clock domain and binding to the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module pfl_pin_ctrl_asserts
  import pfl_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_gpio_high,
  input wire logic i_gpio_low,
  input wire logic o_high_side_output,
  input wire logic o_low_side_output,
  input wire logic o_high_side_owned,
  input wire logic o_low_side_owned,
  input wire logic o_fault_event,
  input wire logic o_limit_event
);
  logic ctrl_wr;
  assign ctrl_wr = i_avs_write && !o_avs_waitrequest && (i_avs_address[3:0] == PFL_OFS_CTRL);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  sequence s_seen;
    (i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  property p_bus_answer;
    s_seen |=> s_answer;
  endproperty
  property p_rd_stands;
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata);
  endproperty
  property p_rsvd_zero;
    (o_avs_readdata & 32'hc080_0000) == 32'h0;
  endproperty
  // Past guard: the edge after release still shows reset levels
  property p_high_gpio;
    !o_high_side_owned && $past(i_clk_en) && !$past(i_sys_rst) |-> o_high_side_output == $past(i_gpio_high);
  endproperty
  property p_low_gpio;
    !o_low_side_owned && $past(i_clk_en) && !$past(i_sys_rst) |-> o_low_side_output == $past(i_gpio_low);
  endproperty
  property p_flt_pulse;
    o_fault_event |=> !o_fault_event;
  endproperty
  property p_lim_pulse;
    o_limit_event |=> !o_limit_event;
  endproperty
  property p_owned_src;
    $changed(o_high_side_owned) || $changed(o_low_side_owned) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");
  a_rd_stands: assert property (p_rd_stands) else $error("read data moved");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read one");
  a_high_gpio: assert property (p_high_gpio) else $error("high pin not gpio");
  a_low_gpio: assert property (p_low_gpio) else $error("low pin not gpio");
  a_flt_pulse: assert property (p_flt_pulse) else $error("fault event too long");
  a_lim_pulse: assert property (p_lim_pulse) else $error("limit event too long");
  a_owned_src: assert property (p_owned_src) else $error("ownership moved alone");
endmodule : pfl_pin_ctrl_asserts
bind pfl_pin_ctrl pfl_pin_ctrl_asserts #(.ADDR_W(ADDR_W)) pfl_pin_ctrl_asserts_i (.*);
`default_nettype wire

// ### dv/pfl_pin_ctrl_bench.sv
/*
  Self-checking bench for pfl_pin_ctrl.
  Assumes the source model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
module pfl_pin_ctrl_bench
  import pfl_pkg::*;
;
  logic clk, rst = 1'b1, rd = 1'b0, wr = 1'b0, fuse = 1'b0, en = 1'b0, bnd = 1'b0;
  logic ce = 1'b1, own_h, own_l, ev_f, ev_l, pf = 1'b0, pl = 1'b0;
  logic pwm_h = 1'b0, pwm_l = 1'b0, gp_h = 1'b0, gp_l = 1'b0, flvl = 1'b0, llvl = 1'b0;
  logic [3:0] addr = 4'h0, fsel = 4'hf, lsel = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, m_ctrl, cw, q, rnd;
  logic [7:0] fpins;
  logic [4:0] cmp;
  logic pin15, wt, out_h, out_l, act;
  int miscompares = 0, n_compared = 0, cyc = 0;
  pfl_src_model pfl_src_model_i (.i_sys_clk(clk), .i_fsel(fsel), .i_flvl(flvl), .i_lsel(lsel),
    .i_llvl(llvl), .o_fault_input_pin(fpins), .o_fault_input_pin15(pin15), .o_comparator(cmp));
  pfl_pin_ctrl pfl_pin_ctrl_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(ce), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .i_config_lock_fuse(fuse), .i_pwm_module_enable(en),
    .i_cycle_boundary(bnd), .i_fault_input_pin(fpins), .i_fault_input_pin15(pin15), .i_comparator(cmp),
    .i_pwm_high(pwm_h), .i_pwm_low(pwm_l), .i_gpio_high(gp_h), .i_gpio_low(gp_l),
    .o_high_side_output(out_h), .o_low_side_output(out_l), .o_high_side_owned(own_h),
    .o_low_side_owned(own_l), .o_fault_event(ev_f), .o_limit_event(ev_l));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) miscompares++;
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wctrl(input logic [31:0] d, input logic open);
    logic [31:0] prot;
    prot = open ? 32'h0 : PFL_CTRL_PROT;
    bus(1'b1, PFL_OFS_CTRL, d, q);
    m_ctrl = (d & PFL_CTRL_IMPL & ~prot) | (m_ctrl & prot);
  endtask : wctrl
  task automatic rdchk();
    bus(1'b0, PFL_OFS_CTRL, 32'h0, q);
    chk(q, m_ctrl);
  endtask : rdchk
  task automatic tick();
    bnd <= 1'b1;
    @(posedge clk);
    bnd <= 1'b0;
    @(posedge clk);
  endtask : tick
  task automatic step(input logic fl, input logic ll, input logic fo, input logic lo);
    logic eh, el;
    logic [1:0] ev;
    rnd = $urandom;
    ev = 2'b00;
    flvl <= fl;
    llvl <= ll;
    {pwm_h, pwm_l, gp_h, gp_l} <= rnd[3:0];
    // Event pulses last one cycle, so watch every edge of the wait
    repeat (3) begin
      @(posedge clk);
      ev = ev | {ev_f, ev_l};
    end
    eh = (fo ? m_ctrl[PFL_FDAT_LSB+1] : lo ? m_ctrl[PFL_LDAT_LSB+1] : rnd[3]) ^ m_ctrl[PFL_HIGH_PIN_POLARITY_BIT];
    el = (fo ? m_ctrl[PFL_FDAT_LSB] : lo ? m_ctrl[PFL_LDAT_LSB] : rnd[2]) ^ m_ctrl[PFL_POLL_BIT];
    eh = m_ctrl[PFL_HIGH_PIN_OWNERSHIP_BIT] ? eh : rnd[1];
    el = m_ctrl[PFL_LOW_PIN_OWNERSHIP_BIT] ? el : rnd[0];
    chk({30'h0, out_h, out_l}, {30'h0, eh, el});
    chk({30'h0, own_h, own_l}, {30'h0, m_ctrl[PFL_HIGH_PIN_OWNERSHIP_BIT], m_ctrl[PFL_LOW_PIN_OWNERSHIP_BIT]});
    chk({30'h0, ev}, {30'h0, fl & !pf, ll & !pl});
    pf = fl;
    pl = ll;
    bus(1'b0, PFL_OFS_STAT, 32'h0, q);
    chk({27'h0, q[4:0]}, {28'h0, lo, fo, ll, fl});
  endtask : step
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(15322));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    m_ctrl = PFL_CTRL_RST;
    rdchk();
    bus(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    wctrl(32'hffff_ffff, 1'b0);
    rdchk();
    bus(1'b1, PFL_OFS_KEY, {16'h0, PFL_KEY_FIRST}, q);
    bus(1'b1, PFL_OFS_KEY, {16'h0, PFL_KEY_SECOND}, q);
    wctrl($urandom, 1'b1);
    rdchk();
    bus(1'b1, PFL_OFS_KEY, {16'h0, PFL_KEY_FIRST}, q);
    bus(1'b0, PFL_OFS_STAT, 32'h0, q);
    bus(1'b1, PFL_OFS_KEY, {16'h0, PFL_KEY_SECOND}, q);
    wctrl(~m_ctrl, 1'b0);
    rdchk();
    fuse <= 1'b1;
    wctrl(~m_ctrl, 1'b1);
    rdchk();
    // Sources only move while the module is off
    for (int c = 0; c < 32; c++) begin
      rnd = $urandom;
      cw = PFL_CTRL_RST;
      cw[PFL_FSRC_LSB+:4] = c[4:1];
      cw[PFL_LSRC_LSB+:4] = c[4:1];
      cw[PFL_FPOL_BIT] = c[0];
      cw[PFL_LPOL_BIT] = !c[0];
      wctrl(cw, 1'b1);
      fsel <= c[4:1];
      lsel <= c[4:1];
      flvl <= rnd[0];
      llvl <= rnd[0];
      repeat (3) @(posedge clk);
      bus(1'b0, PFL_OFS_STAT, 32'h0, q);
      act = (c[4:1] != 4'hd && c[4:1] != 4'he);
      chk({30'h0, q[1:0]}, {30'h0, act & (rnd[0] ^ !c[0]), act & (rnd[0] ^ c[0])});
    end
    fsel <= 4'h0;
    lsel <= 4'h1;
    rnd = $urandom;
    cw = 32'h0;
    cw[PFL_HIGH_PIN_OWNERSHIP_BIT+:2] = 2'h3;
    cw[PFL_POLL_BIT+:2] = rnd[1:0];
    cw[PFL_FDAT_LSB+:2] = rnd[3:2];
    cw[PFL_LDAT_LSB+:2] = rnd[5:4];
    cw[PFL_LSRC_LSB+:4] = 4'h1;
    cw[PFL_CURRENT_LIMIT_OVERRIDE_ENABLE_BIT] = 1'b1;
    cw[PFL_FMOD_LSB+:2] = PFL_FMOD_CYCLE;
    wctrl(cw, 1'b1);
    en <= 1'b1;
    tick();
    step(1'b0, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b1);
    step(1'b1, 1'b1, 1'b1, 1'b1);
    step(1'b0, 1'b1, 1'b0, 1'b1);
    cw[PFL_CURRENT_LIMIT_OVERRIDE_ENABLE_BIT] = 1'b0;
    wctrl(cw, 1'b1);
    tick();
    step(1'b0, 1'b1, 1'b0, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    cw[PFL_CURRENT_LIMIT_OVERRIDE_ENABLE_BIT] = 1'b1;
    wctrl(cw, 1'b1);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    tick();
    step(1'b0, 1'b1, 1'b0, 1'b1);
    cw[PFL_FMOD_LSB+:2] = PFL_FMOD_LATCH;
    wctrl(cw, 1'b1);
    tick();
    step(1'b1, 1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b1, 1'b0);
    bus(1'b1, PFL_OFS_STAT, 32'h4, q);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    cw[PFL_FMOD_LSB+:2] = PFL_FMOD_CYCLE;
    wctrl(cw, 1'b1);
    tick();
    step(1'b1, 1'b0, 1'b1, 1'b0);
    cw[PFL_FMOD_LSB+:2] = 2'h3;
    wctrl(cw, 1'b1);
    tick();
    step(1'b1, 1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b0, 1'b0);
    cw[PFL_FMOD_LSB+:2] = 2'h2;
    wctrl(cw, 1'b1);
    tick();
    step(1'b1, 1'b0, 1'b0, 1'b0);
    cw[PFL_HIGH_PIN_OWNERSHIP_BIT+:2] = 2'h0;
    wctrl(cw, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    // Clock enable low freezes the pins even though the GPIO data moves
    ce <= 1'b0;
    {gp_h, gp_l} <= ~rnd[1:0];
    repeat (3) @(posedge clk);
    chk({30'h0, out_h, out_l}, {30'h0, rnd[1:0]});
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk({30'h0, out_h, out_l}, {30'h0, ~rnd[1:0]});
    tally_and_finish();
  end
endmodule : pfl_pin_ctrl_bench
`default_nettype wire

// ### dv/pfl_src_model.sv
/*
  Fault and limit source model: pins 1-8, pin 15, comparators 1-5.
  Assumes the bench picks the selected lines and their levels.
*/
`timescale 1ns/1ps
`default_nettype none
module pfl_src_model (
  input wire logic i_sys_clk,
  input wire logic [3:0] i_fsel,
  input wire logic i_flvl,
  input wire logic [3:0] i_lsel,
  input wire logic i_llvl,
  output logic [7:0] o_fault_input_pin,
  output logic o_fault_input_pin15,
  output logic [4:0] o_comparator
);
  logic [15:0] noise_reg;
  logic [15:0] lines;
  // Unselected lines churn so a wrong select cannot pass by luck
  always_ff @(posedge i_sys_clk) begin
    noise_reg <= 16'($urandom);
  end
  always_comb begin
    lines = noise_reg;
    lines[i_lsel] = i_llvl;
    lines[i_fsel] = i_flvl;
  end
  assign o_fault_input_pin = lines[7:0];
  assign o_comparator = lines[12:8];
  assign o_fault_input_pin15 = lines[15];
endmodule : pfl_src_model
`default_nettype wire

// ### verilog/pfl_pin_ctrl.sv
/*
  Output-stage control for one PWM generator: fault and current-limit
  source select, polarity, override modes, pin ownership and polarity,
  and a two-word key lock on the protected control fields.
  Assumes a synchronous time base that pulses i_cycle_boundary for one
  clock per PWM cycle, and generator data where 1 means active level.
*/
// Local design decisions: the register offsets and register access over Avalon-MM.
// Overview of operation
// - With limit override enabled, an active limit input overrides both pins.
// - With limit override disabled, no pin override; limit events still raised.
// - An active fault override beats the limit override on the pin pair.
// - Limit enable and fault mode load at each cycle boundary once enabled.
// - Clearing limit enable keeps an existing limit override while input active.
// - Fault mode set to disabled keeps an existing fault override while active.
// - Fault source: 1111 pin 15, 1100-1000 comparators 5-1, 0111-0000 pins 8-1.
// - Fault polarity 1 means source active-low, 0 active-high.
// - Fault mode 11 disables fault overrides, fault events still raised; 10 reserved.
// - Fault mode 01 forces fault states cycle by cycle, released when fault clears.
// - Fault mode 00 forces fault states and latches them.
// - High ownership 1 lets the generator drive high pin, else GPIO.
// - Low ownership 1 lets the generator drive low pin, else GPIO.
// - High polarity 1 makes the high pin active-low.
// - Low polarity 1 makes the low pin active-low.
// - Fault and limit states are active levels translated through pin polarity.
// - With fuse 0, protected fields take writes only after keys abcd then 4321.
// - With fuse 1, protected fields take writes at any time.
// - Control bit 23 ignores writes and reads zero.
// - Fault state bit 1 sets high pin, bit 0 low pin, during fault override.
// - Limit state bit 1 sets high pin, bit 0 low pin, during limit override.
// - Limit polarity 1 means source active-low, 0 active-high.
`timescale 1ns/1ps
`default_nettype none

module pfl_pin_ctrl
  import pfl_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int NUM_FLT_PINS = 8,
  parameter int NUM_CMP = 5
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // System
  input wire logic i_config_lock_fuse,
  input wire logic i_pwm_module_enable,
  input wire logic i_cycle_boundary,
  // Fault and limit sources
  input wire logic [NUM_FLT_PINS-1:0] i_fault_input_pin,
  input wire logic i_fault_input_pin15,
  input wire logic [NUM_CMP-1:0] i_comparator,
  // Generator and GPIO data
  input wire logic i_pwm_high,
  input wire logic i_pwm_low,
  input wire logic i_gpio_high,
  input wire logic i_gpio_low,
  // Pins
  output logic o_high_side_output,
  output logic o_low_side_output,
  output logic o_high_side_owned,
  output logic o_low_side_owned,
  output logic o_fault_event,
  output logic o_limit_event
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Source decode shared by fault and limit paths; polarity applied here
  // so reserved codes stay inactive whatever the polarity bit says
  function automatic logic src_sel(input logic [3:0] code,
                                   input logic [NUM_FLT_PINS-1:0] pins,
                                   input logic pin15,
                                   input logic [NUM_CMP-1:0] cmps, input logic act_low);
    logic r;
    r = 1'b0;
    if (code == PFL_SRC_PIN15) begin
      r = pin15 ^ act_low;
    end else if (code >= PFL_SRC_CMP_LO && code <= PFL_SRC_CMP_HI) begin
      r = cmps[3'(code - PFL_SRC_CMP_LO)] ^ act_low;
    end else if (code < PFL_SRC_CMP_LO) begin
      r = pins[3'(code)] ^ act_low;
    end
    return r;
  endfunction : src_sel

  // Active level to pin level
  function automatic logic pin_level(input logic state, input logic act_low);
    return state ^ act_low;
  endfunction : pin_level

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake

  logic wait_reg;
  logic wait_next;
  logic req;
  logic acc;
  logic acc_wr;
  logic [3:0] addr_lo;

  assign req = i_avs_read | i_avs_write;
  // Answer one cycle after the request is seen, then drop back high
  assign wait_next = ~(req & wait_reg);
  assign acc = req & ~wait_reg;
  assign acc_wr = i_avs_write & ~wait_reg;
  assign addr_lo = i_avs_address[3:0];

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wait_reg <= 1'b1;
    end else if (i_clk_en) begin
      wait_reg <= wait_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock sequence

  pfl_unlock_t unl_reg;
  pfl_unlock_t unl_next;
  logic key_wr;

  assign key_wr = acc_wr && addr_lo == PFL_OFS_KEY;

  always_comb begin
    unl_next = unl_reg;
    if (acc) begin
      case (unl_reg)
        PFL_UNL_IDLE: begin
          unl_next = (key_wr && i_avs_writedata[15:0] == PFL_KEY_FIRST) ? PFL_UNL_KEY1 : PFL_UNL_IDLE;
        end
        PFL_UNL_KEY1: begin
          unl_next = (key_wr && i_avs_writedata[15:0] == PFL_KEY_SECOND) ? PFL_UNL_OPEN : PFL_UNL_IDLE;
        end
        PFL_UNL_OPEN: begin
          // Any access spends the unlock, whatever it was
          unl_next = PFL_UNL_IDLE;
        end
        default: begin
          unl_next = PFL_UNL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      unl_reg <= PFL_UNL_IDLE;
    end else if (i_clk_en) begin
      unl_reg <= unl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register

  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] wr_mask;
  logic prot_ok;

  assign prot_ok = i_config_lock_fuse | (unl_reg == PFL_UNL_OPEN);
  // Bit 23 and unmodelled fields are outside the implemented mask
  assign wr_mask = lane_mask(i_avs_byteenable) & PFL_CTRL_IMPL & (prot_ok ? 32'hffff_ffff : ~PFL_CTRL_PROT);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (acc_wr && addr_lo == PFL_OFS_CTRL) begin
      ctrl_next = (ctrl_reg & ~wr_mask) | (i_avs_writedata & wr_mask);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= PFL_CTRL_RST;
    end else if (i_clk_en) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Field views
  logic [3:0] lim_src;
  logic lim_pol;
  logic current_limit_override_enable_sw;
  logic [3:0] flt_src;
  logic flt_pol;
  logic [1:0] fmod_sw;
  logic [1:0] flt_dat;
  logic [1:0] lim_dat;

  assign lim_src = ctrl_reg[PFL_LSRC_LSB +: 4];
  assign lim_pol = ctrl_reg[PFL_LPOL_BIT];
  assign current_limit_override_enable_sw = ctrl_reg[PFL_CURRENT_LIMIT_OVERRIDE_ENABLE_BIT];
  assign flt_src = ctrl_reg[PFL_FSRC_LSB +: 4];
  assign flt_pol = ctrl_reg[PFL_FPOL_BIT];
  assign fmod_sw = ctrl_reg[PFL_FMOD_LSB +: 2];
  assign flt_dat = ctrl_reg[PFL_FDAT_LSB +: 2];
  assign lim_dat = ctrl_reg[PFL_LDAT_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // Modes in force, loaded at cycle boundaries

  logic current_limit_override_enable_act_reg;
  logic [1:0] fmod_act_reg;

  // Reset state: overrides off until the first boundary after enable
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      current_limit_override_enable_act_reg <= 1'b0;
      fmod_act_reg <= 2'b11;
    end else if (i_clk_en && i_cycle_boundary && i_pwm_module_enable) begin
      current_limit_override_enable_act_reg <= current_limit_override_enable_sw;
      fmod_act_reg <= fmod_sw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source detection

  logic flt_active;
  logic lim_active;

  assign flt_active = src_sel(flt_src, i_fault_input_pin, i_fault_input_pin15, i_comparator, flt_pol);
  assign lim_active = src_sel(lim_src, i_fault_input_pin, i_fault_input_pin15, i_comparator, lim_pol);

  ////////////////////////////////////////////////////////////////////////
  // Fault override

  logic flt_ovr_reg;
  logic flt_ovr_next;
  logic flt_clr;

  // Latched override is released by writing 1 to its status bit
  assign flt_clr = acc_wr && addr_lo == PFL_OFS_STAT && i_avs_byteenable[0] && i_avs_writedata[PFL_ST_FLT_OVR];

  always_comb begin
    case (fmod_act_reg)
      PFL_FMOD_LATCH: begin
        // Set wins over a clear in the same cycle
        flt_ovr_next = flt_active | (flt_ovr_reg & ~flt_clr);
      end
      PFL_FMOD_CYCLE: begin
        flt_ovr_next = flt_active;
      end
      default: begin
        // Disabled or reserved: no new override, an old one holds while active
        flt_ovr_next = flt_ovr_reg & flt_active;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flt_ovr_reg <= 1'b0;
    end else if (i_clk_en) begin
      flt_ovr_reg <= flt_ovr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Current-limit override

  logic lim_ovr_reg;
  logic lim_ovr_next;

  always_comb begin
    if (current_limit_override_enable_act_reg) begin
      lim_ovr_next = lim_active;
    end else begin
      lim_ovr_next = lim_ovr_reg & lim_active;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      lim_ovr_reg <= 1'b0;
    end else if (i_clk_en) begin
      lim_ovr_reg <= lim_ovr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events, raised in every mode

  logic flt_prev_reg;
  logic lim_prev_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flt_prev_reg <= 1'b0;
      lim_prev_reg <= 1'b0;
      o_fault_event <= 1'b0;
      o_limit_event <= 1'b0;
    end else if (i_clk_en) begin
      flt_prev_reg <= flt_active;
      lim_prev_reg <= lim_active;
      o_fault_event <= flt_active & ~flt_prev_reg;
      o_limit_event <= lim_active & ~lim_prev_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin data path

  logic [1:0] state_sel;

  always_comb begin
    if (flt_ovr_reg) begin
      state_sel = flt_dat;
    end else if (lim_ovr_reg) begin
      state_sel = lim_dat;
    end else begin
      state_sel = {i_pwm_high, i_pwm_low};
    end
  end

  // Registered pins; ownership bits are expected stable before enable
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_high_side_output <= 1'b0;
      o_low_side_output <= 1'b0;
      o_high_side_owned <= 1'b0;
      o_low_side_owned <= 1'b0;
    end else if (i_clk_en) begin
      o_high_side_owned <= ctrl_reg[PFL_HIGH_PIN_OWNERSHIP_BIT];
      o_low_side_owned <= ctrl_reg[PFL_LOW_PIN_OWNERSHIP_BIT];
      o_high_side_output <= ctrl_reg[PFL_HIGH_PIN_OWNERSHIP_BIT] ?
        pin_level(state_sel[1], ctrl_reg[PFL_HIGH_PIN_POLARITY_BIT]) : i_gpio_high;
      o_low_side_output <= ctrl_reg[PFL_LOW_PIN_OWNERSHIP_BIT] ?
        pin_level(state_sel[0], ctrl_reg[PFL_POLL_BIT]) : i_gpio_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] rd_next;
  logic [31:0] stat_word;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[PFL_ST_FLT_ACT] = flt_active;
    stat_word[PFL_ST_LIM_ACT] = lim_active;
    stat_word[PFL_ST_FLT_OVR] = flt_ovr_reg;
    stat_word[PFL_ST_LIM_OVR] = lim_ovr_reg;
    stat_word[PFL_ST_UNLOCK] = unl_reg == PFL_UNL_OPEN;
  end

  always_comb begin
    case (addr_lo)
      PFL_OFS_CTRL: begin
        rd_next = ctrl_reg & PFL_CTRL_IMPL;
      end
      PFL_OFS_STAT: begin
        rd_next = stat_word;
      end
      default: begin
        // Key register and unmapped words read zero
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  // Loaded on the first request edge so it stands at the answer edge
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_clk_en && i_avs_read && wait_reg) begin
      o_avs_readdata <= rd_next;
    end
  end

  assign o_avs_waitrequest = wait_reg;

endmodule : pfl_pin_ctrl

`default_nettype wire
